/* regulator_mode_slew_pkg.sv */
// Shared constants for the regulator mode and slew control block
package regulator_mode_slew_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] MODE_CTRL_OFFSET = 8'h02;
  localparam logic [7:0] TRANSITION_AND_SLEW_CONTROL_OFFSET = 8'h03;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h05;

  // Mode control register fields
  localparam int unsigned LOW_SELECT_PWM_FORCE_BIT = 0;
  localparam int unsigned ALT_SETTING_PWM_FORCE_BIT = 1;
  localparam int unsigned MODE_FIELD_LSB = 2;
  localparam int unsigned MODE_FIELD_MSB = 3;
  localparam int unsigned HW_SW_CONTROL_SELECT_BIT = 4;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;

  // Transition and slew control register fields
  localparam int unsigned SLEW_LSB = 0;
  localparam int unsigned SLEW_MSB = 2;
  localparam int unsigned RESERVED_LSB = 3;
  localparam int unsigned RESERVED_MSB = 4;
  localparam int unsigned POWER_GOOD_FLAG_BIT = 5;
  localparam int unsigned OFF_PULLDOWN_ENABLE_BIT = 6;
  localparam int unsigned TRANSITION_GO_BIT = 7;
  localparam logic [2:0] SLEW_RESET = 3'h0;
  localparam logic OFF_PULLDOWN_RESET = 1'b0;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_PG_LOST_BIT = 1;
  localparam int unsigned IRQ_PG_GAINED_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Light-load mode field codes
  typedef enum logic [1:0] {
    MODE_FOLLOW_BITS = 2'h0,
    MODE_PFM_AUTO_A = 2'h1,
    MODE_FORCE_PWM = 2'h2,
    MODE_PFM_AUTO_B = 2'h3
  } mode_field_t;

  // Rising slew codes; rates in mV per us
  localparam logic [2:0] SLEW_0P15 = 3'h0;
  localparam logic [2:0] SLEW_0P30 = 3'h1;
  localparam logic [2:0] SLEW_0P60 = 3'h2;
  localparam logic [2:0] SLEW_1P20 = 3'h3;
  localparam logic [2:0] SLEW_2P40 = 3'h4;
  localparam logic [2:0] SLEW_4P80 = 3'h5;
  localparam logic [2:0] SLEW_9P60 = 3'h6;
  localparam int unsigned SLEW_BASE_UV_PER_US = 150;

  localparam int unsigned SYNC_STAGES = 2;

endpackage

/* level_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

/* regulator_mode_slew_control.sv */
// Mode policy, transition trigger, discharge and slew control registers
// Function
// RULE_01 - Mode field code 10 forces PWM regardless of voltage select pin.
// RULE_02 - Mode field code 11 runs PFM with automatic PWM transitions always.
// RULE_03 - Under second voltage setting, alternate force bit 1 forces PWM, else PFM.
// RULE_04 - Low select force bit sets light-load policy while select pin low.
// RULE_05 - Trigger bit writes are ignored while hardware control is selected.
// RULE_06 - Writing trigger 1 under software control starts a voltage transition.
// RULE_07 - Trigger bit clears itself when the transition completes.
// RULE_08 - Discharge enable plus regulator disabled turns on the output pull-down.
// RULE_09 - Power-good bit is read-only: 1 in regulation, 0 otherwise.
// RULE_10 - Slew field bits 2:0 choose rising slew rate 0.15 to 9.60 mV/us.
// RULE_11 - Bits 4:3 are reserved, read zero and have no function.
// RULE_12 - Trigger bit reads 1 from accepted start until transition completion.
module regulator_mode_slew_control (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic voltage_select_pin_i,
  input wire logic power_good_i,
  input wire logic regulator_enable_i,
  input wire logic transition_done_i,
  output logic pwm_force_o,
  output logic second_voltage_setting_o,
  output logic transition_start_o,
  output logic transition_busy_o,
  output logic [2:0] slew_code_o,
  output logic off_pulldown_o,
  output logic irq_o
);

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // Pin and analog status inputs
  logic [3:0] pins_sync;
  logic voltage_select_pin;
  logic pg;
  logic reg_en;
  logic done_lvl;

  level_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .async_i({transition_done_i, regulator_enable_i, power_good_i, voltage_select_pin_i}),
    .sync_o(pins_sync)
  );

  assign voltage_select_pin = pins_sync[0];
  assign pg = pins_sync[1];
  assign reg_en = pins_sync[2];
  assign done_lvl = pins_sync[3];

  logic voltage_select_pin_prev_reg;
  logic pg_prev_reg;
  logic done_prev_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      voltage_select_pin_prev_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      voltage_select_pin_prev_reg <= voltage_select_pin;
      pg_prev_reg <= pg;
      done_prev_reg <= done_lvl;
    end
  end

  logic done_pulse;
  logic pg_rise;
  logic pg_fall;
  logic voltage_select_pin_change;

  assign done_pulse = done_lvl & ~done_prev_reg;
  assign pg_rise = pg & ~pg_prev_reg;
  assign pg_fall = ~pg & pg_prev_reg;
  assign voltage_select_pin_change = voltage_select_pin ^ voltage_select_pin_prev_reg;

  // Register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_mode;
  logic wr_tsc;
  logic wr_stat;
  logic wr_mask;

  assign wr_mode = wr_i & hit(addr_i, regulator_mode_slew_pkg::MODE_CTRL_OFFSET);
  assign wr_tsc = wr_i & hit(addr_i, regulator_mode_slew_pkg::TRANSITION_AND_SLEW_CONTROL_OFFSET);
  assign wr_stat = wr_i & hit(addr_i, regulator_mode_slew_pkg::IRQ_STATUS_OFFSET);
  assign wr_mask = wr_i & hit(addr_i, regulator_mode_slew_pkg::IRQ_MASK_OFFSET);

  // Mode control register
  logic [1:0] mode_field_reg;
  logic alt_setting_pwm_force_reg;
  logic low_select_pwm_force_reg;
  logic hw_sw_control_select_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_field_reg <= regulator_mode_slew_pkg::MODE_CTRL_RESET[3:2];
      alt_setting_pwm_force_reg <= regulator_mode_slew_pkg::MODE_CTRL_RESET[1];
      low_select_pwm_force_reg <= regulator_mode_slew_pkg::MODE_CTRL_RESET[0];
      hw_sw_control_select_reg <= regulator_mode_slew_pkg::MODE_CTRL_RESET[4];
    end else if (wr_mode) begin
      mode_field_reg <= wdata_i[regulator_mode_slew_pkg::MODE_FIELD_MSB:regulator_mode_slew_pkg::MODE_FIELD_LSB];
      alt_setting_pwm_force_reg <= wdata_i[regulator_mode_slew_pkg::ALT_SETTING_PWM_FORCE_BIT];
      low_select_pwm_force_reg <= wdata_i[regulator_mode_slew_pkg::LOW_SELECT_PWM_FORCE_BIT];
      hw_sw_control_select_reg <= wdata_i[regulator_mode_slew_pkg::HW_SW_CONTROL_SELECT_BIT];
    end
  end

  // Light-load policy
  logic pwm_force_next;

  always_comb begin
    pwm_force_next = 1'b0;
    unique case (regulator_mode_slew_pkg::mode_field_t'(mode_field_reg))
      regulator_mode_slew_pkg::MODE_FOLLOW_BITS: begin
        if (voltage_select_pin) begin
          pwm_force_next = alt_setting_pwm_force_reg; // RULE_03
        end else begin
          pwm_force_next = low_select_pwm_force_reg; // RULE_04
        end
      end
      regulator_mode_slew_pkg::MODE_PFM_AUTO_A: begin
        pwm_force_next = 1'b0;
      end
      regulator_mode_slew_pkg::MODE_FORCE_PWM: begin
        pwm_force_next = 1'b1; // RULE_01
      end
      regulator_mode_slew_pkg::MODE_PFM_AUTO_B: begin
        pwm_force_next = 1'b0; // RULE_02
      end
    endcase
  end

  logic pwm_force_reg;
  logic second_setting_reg;

  // Registered so the power stage never sees a decode glitch
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwm_force_reg <= 1'b0;
      second_setting_reg <= 1'b0;
    end else begin
      pwm_force_reg <= pwm_force_next;
      second_setting_reg <= voltage_select_pin;
    end
  end

  // Transition trigger
  logic go_reg;
  logic sw_start;
  logic hw_start;
  logic start;

  assign sw_start = wr_tsc & wdata_i[regulator_mode_slew_pkg::TRANSITION_GO_BIT]
                  & ~hw_sw_control_select_reg & ~go_reg; // RULE_05 RULE_06
  assign hw_start = hw_sw_control_select_reg & voltage_select_pin_change & ~go_reg;
  assign start = sw_start | hw_start;

  // Start beats completion, but a go in the completion cycle is dropped since start needs go_reg low
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      go_reg <= 1'b0;
    end else if (start) begin
      go_reg <= 1'b1; // RULE_12
    end else if (done_pulse) begin
      go_reg <= 1'b0; // RULE_07
    end
  end

  logic start_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start;
    end
  end

  // Discharge and slew
  logic off_pulldown_enable_reg;
  logic [2:0] slew_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      off_pulldown_enable_reg <= regulator_mode_slew_pkg::OFF_PULLDOWN_RESET;
      slew_reg <= regulator_mode_slew_pkg::SLEW_RESET;
    end else if (wr_tsc) begin
      off_pulldown_enable_reg <= wdata_i[regulator_mode_slew_pkg::OFF_PULLDOWN_ENABLE_BIT];
      slew_reg <= wdata_i[regulator_mode_slew_pkg::SLEW_MSB:regulator_mode_slew_pkg::SLEW_LSB]; // RULE_10
    end
  end

  logic pulldown_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_reg <= 1'b0;
    end else begin
      pulldown_reg <= off_pulldown_enable_reg & ~reg_en; // RULE_08
    end
  end

  // Interrupts
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_events;

  assign irq_events = {pg_rise, pg_fall, done_pulse & go_reg};

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 3'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | irq_events;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= regulator_mode_slew_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata_i[2:0];
    end
  end

  logic irq_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |((irq_status_reg & ~(wr_stat ? wdata_i[2:0] : 3'h0) | irq_events) & irq_mask_reg);
    end
  end

  // Read path; unmapped offsets read zero
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  always_comb begin
    rdata_next = 8'h00;
    if (hit(addr_i, regulator_mode_slew_pkg::MODE_CTRL_OFFSET)) begin
      rdata_next = {3'h0, hw_sw_control_select_reg, mode_field_reg,
                    alt_setting_pwm_force_reg, low_select_pwm_force_reg};
    end else if (hit(addr_i, regulator_mode_slew_pkg::TRANSITION_AND_SLEW_CONTROL_OFFSET)) begin
      rdata_next = {go_reg, off_pulldown_enable_reg, pg, 2'h0, slew_reg}; // RULE_09 RULE_11
    end else if (hit(addr_i, regulator_mode_slew_pkg::IRQ_STATUS_OFFSET)) begin
      rdata_next = {5'h00, irq_status_reg};
    end else if (hit(addr_i, regulator_mode_slew_pkg::IRQ_MASK_OFFSET)) begin
      rdata_next = {5'h00, irq_mask_reg};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_o = rdata_reg;
  assign pwm_force_o = pwm_force_reg;
  assign second_voltage_setting_o = second_setting_reg;
  assign transition_start_o = start_reg;
  assign transition_busy_o = go_reg;
  assign slew_code_o = slew_reg;
  assign off_pulldown_o = pulldown_reg;
  assign irq_o = irq_reg;

endmodule

/* regulator_mode_slew_properties.sv */
// Port-level checks for the regulator mode and slew control block
module regulator_mode_slew_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic regulator_enable_i,
  input wire logic transition_done_i,
  input wire logic pwm_force_o,
  input wire logic transition_start_o,
  input wire logic transition_busy_o,
  input wire logic [2:0] slew_code_o,
  input wire logic off_pulldown_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the control-select bit, since the checker cannot see the register
  logic hw_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hw_reg <= 1'b0;
    end else if (wr_i && addr_i == 8'h02) begin
      hw_reg <= wdata_i[4];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence go_wr;
    wr_i && addr_i == 8'h03 && wdata_i[7] && !transition_busy_o;
  endsequence
  // Busy and the start pulse both launch on the edge that takes the write
  sequence go_seen;
    transition_busy_o && transition_start_o ##1 transition_busy_o;
  endsequence
  chk_force_pwm: assert property (wr_i && addr_i == 8'h02 && wdata_i[3:2] == 2'h2 |-> ##2 pwm_force_o)
    else $error("no forced pwm");
  chk_sw_go: assert property (go_wr ##0 !hw_reg |=> go_seen)
    else $error("go not started");
  chk_hw_go: assert property (go_wr ##0 hw_reg |=> !transition_busy_o)
    else $error("go taken in hw mode");
  chk_start_pulse: assert property (transition_start_o |=> !transition_start_o)
    else $error("start too long");
  chk_busy_release: assert property ($fell(transition_busy_o) |-> $past(transition_done_i, 2))
    else $error("busy dropped early");
  chk_busy_holds: assert property (transition_busy_o && !transition_done_i |=> transition_busy_o)
    else $error("busy lost");
  chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("stray read data");
  chk_pulldown_off: assert property (regulator_enable_i [*5] |-> !off_pulldown_o)
    else $error("pulldown while on");
  chk_slew_write: assert property (wr_i && addr_i == 8'h03 |-> ##2 slew_code_o == $past(wdata_i[2:0], 2))
    else $error("slew not taken");
endmodule

bind regulator_mode_slew_control regulator_mode_slew_properties i_props (.sys_clk_i, .rst_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .regulator_enable_i, .transition_done_i, .pwm_force_o,
  .transition_start_o, .transition_busy_o, .slew_code_o, .off_pulldown_o);

/* regulator_ramp_model.sv */
// Output ramp model: flags the end of a voltage transition after a set wait
module regulator_ramp_model (
  input wire logic sys_clk_i,
  input wire logic start_i,
  input wire logic busy_i,
  input wire logic [7:0] wait_i,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  initial done_o = 1'b0;
  always @(posedge sys_clk_i) begin
    if (start_i) begin
      cnt_reg <= wait_i;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
      done_o <= (cnt_reg == 8'h01);
    end else if (!busy_i) begin
      // Held until the block drops busy, so a completion is never missed
      done_o <= 1'b0;
    end
  end
endmodule

/* test_regulator_mode_slew_control.sv */
// Self-checking bench for the regulator mode and slew control block
module test_regulator_mode_slew_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_n_i, wr_i, rd_i, voltage_select_pin_i, power_good_i, regulator_enable_i;
  logic transition_done_i, pwm_force_o, second_voltage_setting_o, transition_start_o;
  logic transition_busy_o, off_pulldown_o, irq_o;
  logic [7:0] addr_i, wdata_i, rdata_o, wait_r, e;
  logic [2:0] slew_code_o;
  int n_errors = 0;
  int total_checks = 0;
  int n_starts = 0;
  regulator_mode_slew_control i_dut (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .voltage_select_pin_i, .power_good_i, .regulator_enable_i, .transition_done_i, .pwm_force_o,
    .second_voltage_setting_o, .transition_start_o, .transition_busy_o, .slew_code_o, .off_pulldown_o, .irq_o);
  regulator_ramp_model i_ramp (.sys_clk_i, .start_i(transition_start_o), .busy_i(transition_busy_o),
    .wait_i(wait_r), .done_o(transition_done_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (transition_start_o === 1'b1) n_starts++;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata_o, x);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 200 && transition_busy_o !== 1'b0; i++) @(posedge sys_clk_i);
  endtask
  task automatic t_reset;
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    rchk(8'h05, 8'h00);
    wr(8'h7f, 8'hff);
    rchk(8'h7f, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_modes;
    for (int p = 0; p < 2; p++) begin
      voltage_select_pin_i <= p[0];
      cyc(6);
      chk(8'(second_voltage_setting_o), 8'(p));
      for (int v = 0; v < 16; v++) begin
        wr(8'h02, 8'(v));
        cyc(3);
        e = (v[3:2] == 2) ? 8'h01 : (v[3:2] == 0) ? 8'(p ? v[1] : v[0]) : 8'h00;
        chk(8'(pwm_force_o), e);
      end
    end
    $display("test modes done");
  endtask
  task automatic t_slew;
    power_good_i <= 1'b1;
    cyc(6);
    for (int s = 0; s < 8; s++) begin
      e = 8'(s) | (8'(s[0]) << 6);
      // Power-good and reserved bits written as one must not stick
      wr(8'h03, e | 8'h38);
      rchk(8'h03, e | 8'h20);
      chk(8'(slew_code_o), 8'(s));
      chk(8'(off_pulldown_o), 8'(s[0]));
    end
    regulator_enable_i <= 1'b1;
    power_good_i <= 1'b0;
    cyc(6);
    chk(8'(off_pulldown_o), 8'h00);
    rchk(8'h03, 8'h47);
    $display("test slew done");
  endtask
  task automatic t_trans(input logic [7:0] w);
    int n0;
    n0 = n_starts;
    wait_r <= w;
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h07);
    wr(8'h05, 8'h00);
    wr(8'h03, 8'h80);
    rchk(8'h03, 8'h80);
    // A second go is only meaningful while the slow ramp is surely running
    if (w > 8'h14) wr(8'h03, 8'h80);
    wait_idle;
    cyc(4);
    chk(8'(n_starts - n0), 8'h01);
    rchk(8'h03, 8'h00);
    rchk(8'h04, 8'h01);
    chk(8'(irq_o), 8'h00);
    wr(8'h05, 8'h01);
    cyc(2);
    chk(8'(irq_o), 8'h01);
    wr(8'h04, 8'h01);
    cyc(2);
    chk(8'(irq_o), 8'h00);
    rchk(8'h04, 8'h00);
    $display("test transition done");
  endtask
  task automatic t_hw;
    int n0;
    n0 = n_starts;
    wr(8'h02, 8'h10);
    wr(8'h03, 8'h80);
    cyc(4);
    rchk(8'h03, 8'h00);
    chk(8'(n_starts - n0), 8'h00);
    voltage_select_pin_i <= ~voltage_select_pin_i;
    cyc(8);
    wait_idle;
    chk(8'(n_starts - n0), 8'h01);
    $display("test hw select done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    voltage_select_pin_i = 1'b0;
    power_good_i = 1'b0;
    regulator_enable_i = 1'b0;
    wait_r = 8'h02;
    cyc(8);
    rst_n_i <= 1'b1;
    cyc(6);
    t_reset;
    t_modes;
    t_slew;
    t_trans(8'h02);
    t_trans(8'h28);
    t_hw;
    print_verdict;
  end
  initial begin
    cyc(20000);
    n_errors++;
    print_verdict;
  end
endmodule
